// ### include/spw_pkg.sv
// shared constants for the serial programming link, write and poll sequencing
package spw_pkg;
    // serial frame: opcode, address high, address low, data byte, msb first
    localparam int        CMD_W       = 32;
    localparam int        CNT_W       = 6;
    localparam int        RD_LOAD_BIT = 23;
    localparam int        OP_LSB      = 24;
    localparam int        ADDR_LSB    = 8;
    // flash organisation: 6 word bits inside a page, 8 page select bits
    localparam int        PAGE_W      = 6;
    localparam int        PAGE_SEL_W  = 8;
    localparam int        EE_ADDR_W   = 10;
    localparam logic [7:0] ERASED     = 8'hff;
    // instruction codes carried in the opcode byte
    localparam logic [7:0] OP_LOAD_LO = 8'h40;
    localparam logic [7:0] OP_LOAD_HI = 8'h48;
    localparam logic [7:0] OP_WR_PAGE = 8'h4c;
    localparam logic [7:0] OP_RD_LO   = 8'h20;
    localparam logic [7:0] OP_RD_HI   = 8'h28;
    localparam logic [7:0] OP_EE_WR   = 8'hc0;
    localparam logic [7:0] OP_EE_RD   = 8'ha0;
    // minimum wait delays and the clock they are counted in
    localparam int        CLK_PERIOD_NS = 4;
    localparam int        WD_FLASH_NS   = 4_500_000;
    localparam int        WD_EEPROM_NS  = 3_600_000;
    localparam int        WD_FLASH_CYC  = (WD_FLASH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int        WD_EEPROM_CYC = (WD_EEPROM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // internal programming time, kept well inside the wait delays
    localparam int        FL_PROG_CYC   = WD_FLASH_CYC / 2;
    localparam int        EE_PROG_CYC   = WD_EEPROM_CYC / 2;
    localparam int        TMR_W         = 24;
    // serial clock half period in system clocks
    localparam int        SCK_HALF      = 4;
    localparam int        DIV_W         = 4;
    localparam int        FIFO_DEPTH    = 8;
endpackage

// ### include/spw_if.sv
// serial programming link between programmer and device
interface spw_if;
    logic sck;
    logic mosi;
    logic miso;
    logic prst_n;

    modport prog
    (
        output sck,
        output mosi,
        output prst_n,
        input  miso
    );
    modport dev
    (
        input  sck,
        input  mosi,
        input  prst_n,
        output miso
    );
endinterface

// ### rtl/spw_dev.sv
// device end: serial command decode, page buffer, flash and eeprom arrays, busy polling
module spw_dev
    import spw_pkg::*;
#(
    parameter int PSEL_W = spw_pkg::PAGE_SEL_W,
    parameter int EE_AW  = spw_pkg::EE_ADDR_W,
    parameter int FL_CYC = spw_pkg::FL_PROG_CYC,
    parameter int EE_CYC = spw_pkg::EE_PROG_CYC
)
(
    input  wire logic clk,
    input  wire logic nrst,
    spw_if.dev        lnk,
    output logic      prog_mode_r,
    output logic      fl_busy_r,
    output logic      ee_busy_r,
    output logic      cmd_drop_r
);
    import spw_pkg::*;

    localparam int PAGE_WORDS = 2 ** PAGE_W;
    localparam int FL_WORDS   = 2 ** (PSEL_W + PAGE_W);
    localparam int EE_BYTES   = 2 ** EE_AW;

    logic              sck_q_r;
    logic [CNT_W-1:0]  bit_r;
    logic [CMD_W-2:0]  sh_r;
    logic [7:0]        rd_r;
    logic              miso_r;
    logic [15:0]       pbuf [PAGE_WORDS];
    logic [15:0]       fl_mem [FL_WORDS];
    logic [7:0]        ee_mem [EE_BYTES];
    logic [PSEL_W-1:0] busy_pg_r;
    logic [EE_AW-1:0]  busy_ee_r;
    logic [TMR_W-1:0]  fl_tmr_r;
    logic [TMR_W-1:0]  ee_tmr_r;
    logic              rise;
    logic              fall;
    logic              done;
    logic              go;
    logic [CMD_W-1:0]  cmd;
    logic [7:0]        opc;
    logic [15:0]       addr;
    logic [7:0]        dat;

    // read value of one location, blanked while its write is in flight
    function automatic logic [7:0] read_byte(input logic [7:0] op, input logic [15:0] a);
        logic [15:0] w;
        w = fl_mem[a[PSEL_W+PAGE_W-1:0]];
        read_byte = ERASED;
        if (op == OP_RD_LO || op == OP_RD_HI)
        begin
            // any word of the busy page polls, since the page is written whole
            if (fl_busy_r && a[PSEL_W+PAGE_W-1:PAGE_W] == busy_pg_r)
                read_byte = ERASED;
            else if (op == OP_RD_LO)
                read_byte = w[7:0];
            else
                read_byte = w[15:8];
        end
        else if (op == OP_EE_RD)
        begin
            if (ee_busy_r && a[EE_AW-1:0] == busy_ee_r)
                read_byte = ERASED;
            else
                read_byte = ee_mem[a[EE_AW-1:0]];
        end
    endfunction

    // serial clock edges, sampled as ordinary synchronous inputs
    assign rise = lnk.sck & ~sck_q_r;
    assign fall = ~lnk.sck & sck_q_r;
    assign done = rise && bit_r == CNT_W'(CMD_W - 1);
    assign cmd  = {sh_r, lnk.mosi};
    assign opc  = cmd[CMD_W-1:OP_LSB];
    assign addr = cmd[OP_LSB-1:ADDR_LSB];
    assign dat  = cmd[7:0];
    // writes and loads landing during a flash page write are ignored, not queued; reads still answer
    assign go   = done && !fl_busy_r;
    assign lnk.miso = miso_r;

    // edge history and programming mode flag
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sck_q_r     <= 1'b0;
            prog_mode_r <= 1'b0;
        end
        else
        begin
            sck_q_r     <= lnk.sck;
            prog_mode_r <= ~lnk.prst_n;
        end
    end

    // frame bit counter and input shifter; a released reset line aborts a frame
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            bit_r <= '0;
            sh_r  <= '0;
        end
        else if (lnk.prst_n)
        begin
            bit_r <= '0;
            sh_r  <= '0;
        end
        else if (rise)
        begin
            bit_r <= done ? '0 : bit_r + CNT_W'(1);
            sh_r  <= cmd[CMD_W-2:0];
        end
    end

    // read byte is fetched once the address is complete, then shifted msb first
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rd_r   <= '0;
            miso_r <= 1'b0;
        end
        else if (rise && bit_r == CNT_W'(RD_LOAD_BIT))
        begin
            rd_r <= read_byte(sh_r[22:15], {sh_r[14:0], lnk.mosi});
        end
        else if (fall && bit_r > CNT_W'(RD_LOAD_BIT))
        begin
            miso_r <= rd_r[7];
            rd_r   <= {rd_r[6:0], 1'b0};
        end
    end

    // sticky report that a command arrived while the flash was busy
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            cmd_drop_r <= 1'b0;
        else if (done && fl_busy_r)
            cmd_drop_r <= 1'b1;
        else if (lnk.prst_n)
            cmd_drop_r <= 1'b0;
    end

    // page buffer: random order fill, cleared to erased after each commit
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            for (int i = 0; i < PAGE_WORDS; i++)
                pbuf[i] <= {ERASED, ERASED};
        end
        else if (go && opc == OP_LOAD_LO)
            pbuf[addr[PAGE_W-1:0]][7:0] <= dat;
        else if (go && opc == OP_LOAD_HI)
            pbuf[addr[PAGE_W-1:0]][15:8] <= dat;
        else if (go && opc == OP_WR_PAGE)
        begin
            for (int i = 0; i < PAGE_WORDS; i++)
                pbuf[i] <= {ERASED, ERASED};
        end
    end

    // flash array: the page is copied in one step, hidden by the busy window
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            for (int i = 0; i < FL_WORDS; i++)
                fl_mem[i] <= {ERASED, ERASED};
        end
        else if (go && opc == OP_WR_PAGE)
        begin
            for (int i = 0; i < PAGE_WORDS; i++)
                fl_mem[{addr[PSEL_W+PAGE_W-1:PAGE_W], PAGE_W'(i)}] <= pbuf[i];
        end
    end

    // eeprom array: a plain overwrite stands for erase then program
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            for (int i = 0; i < EE_BYTES; i++)
                ee_mem[i] <= ERASED;
        end
        else if (go && opc == OP_EE_WR)
            ee_mem[addr[EE_AW-1:0]] <= dat;
    end

    // flash busy window with the page it covers
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            fl_busy_r <= 1'b0;
            fl_tmr_r  <= '0;
            busy_pg_r <= '0;
        end
        else if (go && opc == OP_WR_PAGE)
        begin
            fl_busy_r <= 1'b1;
            fl_tmr_r  <= '0;
            busy_pg_r <= addr[PSEL_W+PAGE_W-1:PAGE_W];
        end
        else if (fl_busy_r)
        begin
            fl_tmr_r <= fl_tmr_r + TMR_W'(1);
            if (fl_tmr_r == TMR_W'(FL_CYC - 1))
                fl_busy_r <= 1'b0;
        end
    end

    // eeprom busy window; a second byte restarts it on the new address
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ee_busy_r <= 1'b0;
            ee_tmr_r  <= '0;
            busy_ee_r <= '0;
        end
        else if (go && opc == OP_EE_WR)
        begin
            ee_busy_r <= 1'b1;
            ee_tmr_r  <= '0;
            busy_ee_r <= addr[EE_AW-1:0];
        end
        else if (ee_busy_r)
        begin
            ee_tmr_r <= ee_tmr_r + TMR_W'(1);
            if (ee_tmr_r == TMR_W'(EE_CYC - 1))
                ee_busy_r <= 1'b0;
        end
    end
endmodule

// ### rtl/spw_prog.sv
// programmer end: command fifo, serial clock divider, frame shifter and wait timer
module spw_fifo
#(
    parameter int W = 32,
    parameter int D = 8
)
(
    input  wire logic         clk,
    input  wire logic         nrst,
    input  wire logic         in_valid,
    output logic              in_ready_r,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid_r,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(D);
    logic [W-1:0]  mem [D];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [AW:0]   cnt_r;
    logic [AW:0]   cnt_nxt;
    logic          push;
    logic          pop;

    assign push     = in_valid && in_ready_r;
    assign pop      = out_valid_r && out_ready;
    assign cnt_nxt  = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    assign out_data = mem[rp_r];

    // pointers wrap by compare so depths need not be powers of two
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            wp_r        <= '0;
            rp_r        <= '0;
            cnt_r       <= '0;
            in_ready_r  <= 1'b1;
            out_valid_r <= 1'b0;
        end
        else
        begin
            if (push)
                wp_r <= (wp_r == AW'(D - 1)) ? '0 : wp_r + AW'(1);
            if (pop)
                rp_r <= (rp_r == AW'(D - 1)) ? '0 : rp_r + AW'(1);
            cnt_r       <= cnt_nxt;
            in_ready_r  <= cnt_nxt != (AW+1)'(D);
            out_valid_r <= cnt_nxt != '0;
        end
    end

    // storage holds no reset, only valid entries are ever read
    always_ff @(posedge clk)
    begin
        if (push)
            mem[wp_r] <= in_data;
    end
endmodule

module spw_prog
    import spw_pkg::*;
#(
    parameter int WD_FL = spw_pkg::WD_FLASH_CYC,
    parameter int WD_EE = spw_pkg::WD_EEPROM_CYC,
    parameter int DEPTH = spw_pkg::FIFO_DEPTH
)
(
    input  wire logic                       clk,
    input  wire logic                       nrst,
    input  wire logic                       sess_en,
    input  wire logic                       cmd_valid,
    output logic                            cmd_ready_r,
    input  wire logic [spw_pkg::CMD_W-1:0]  cmd_data,
    output logic                            rsp_valid_r,
    output logic [7:0]                      rsp_data_r,
    spw_if.prog                             lnk
);
    import spw_pkg::*;

    typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_WAIT} spw_st_type;

    spw_st_type        st_r;
    logic              q_valid;
    logic              q_pop;
    logic [CMD_W-1:0]  q_data;
    logic [CMD_W-1:0]  sh_r;
    logic [DIV_W-1:0]  div_r;
    logic [CNT_W:0]    rises_r;
    logic [7:0]        rx_r;
    logic [TMR_W-1:0]  wait_r;
    logic [TMR_W-1:0]  wait_len_r;
    logic              sck_r;
    logic              mosi_r;
    logic              prst_n_r;
    logic              tick;
    logic              last_fall;

    spw_fifo #(.W(CMD_W), .D(DEPTH)) u_fifo
    (
        .clk         (clk),
        .nrst        (nrst),
        .in_valid    (cmd_valid),
        .in_ready_r  (cmd_ready_r),
        .in_data     (cmd_data),
        .out_valid_r (q_valid),
        .out_ready   (q_pop),
        .out_data    (q_data)
    );

    assign tick      = div_r == DIV_W'(SCK_HALF - 1);
    assign last_fall = tick && sck_r && rises_r == (CNT_W+1)'(CMD_W);
    // a frame only starts with the device held in reset, fifo stalls otherwise
    assign q_pop     = st_r == ST_IDLE && q_valid && !prst_n_r;
    assign lnk.sck    = sck_r;
    assign lnk.mosi   = mosi_r;
    assign lnk.prst_n = prst_n_r;

    // reset line held low for the session, released only when idle;
    // a pop in the same cycle keeps it low so a starting frame is never cut
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            prst_n_r <= 1'b1;
        else
            prst_n_r <= !(sess_en || st_r != ST_IDLE || q_pop);
    end

    // sequencer: shift a frame, then hold off for the fixed wait after writes
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            st_r       <= ST_IDLE;
            wait_r     <= '0;
            wait_len_r <= '0;
        end
        else
        begin
            case (st_r)
                ST_IDLE:
                begin
                    if (q_pop)
                    begin
                        st_r <= ST_SHIFT;
                        // fixed waits cover 0xff data that polling cannot see
                        if (q_data[CMD_W-1:OP_LSB] == OP_WR_PAGE)
                            wait_len_r <= TMR_W'(WD_FL);
                        else if (q_data[CMD_W-1:OP_LSB] == OP_EE_WR)
                            wait_len_r <= TMR_W'(WD_EE);
                        else
                            wait_len_r <= '0;
                    end
                end
                ST_SHIFT:
                begin
                    wait_r <= '0;
                    if (last_fall)
                        st_r <= (wait_len_r == '0) ? ST_IDLE : ST_WAIT;
                end
                ST_WAIT:
                begin
                    // no traffic at all until the write has surely finished
                    wait_r <= wait_r + TMR_W'(1);
                    if (wait_r == wait_len_r - TMR_W'(1))
                        st_r <= ST_IDLE;
                end
                default:
                    st_r <= ST_IDLE;
            endcase
        end
    end

    // serial clock divider and msb-first shifter; mosi moves on falling edges
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            div_r   <= '0;
            sck_r   <= 1'b0;
            mosi_r  <= 1'b0;
            sh_r    <= '0;
            rises_r <= '0;
            rx_r    <= '0;
        end
        else if (q_pop)
        begin
            div_r   <= '0;
            sh_r    <= q_data;
            mosi_r  <= q_data[CMD_W-1];
            rises_r <= '0;
        end
        else if (st_r == ST_SHIFT)
        begin
            div_r <= tick ? '0 : div_r + DIV_W'(1);
            if (tick && !sck_r)
            begin
                sck_r   <= 1'b1;
                rises_r <= rises_r + (CNT_W+1)'(1);
                rx_r    <= {rx_r[6:0], lnk.miso};
            end
            else if (tick)
            begin
                sck_r  <= 1'b0;
                sh_r   <= {sh_r[CMD_W-2:0], 1'b0};
                mosi_r <= sh_r[CMD_W-2];
            end
        end
    end

    // answer pulse with the last byte seen on miso
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rsp_valid_r <= 1'b0;
            rsp_data_r  <= '0;
        end
        else
        begin
            rsp_valid_r <= st_r == ST_SHIFT && last_fall;
            if (st_r == ST_SHIFT && last_fall)
                rsp_data_r <= rx_r;
        end
    end
endmodule

// ### bench/spw_link_monitor.sv
// concurrent checks on the serial programming link and the device busy flags
module spw_link_monitor
#(
    parameter int FL_CYC = 100,
    parameter int EE_CYC = 80
)
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic sck,
    input wire logic mosi,
    input wire logic miso,
    input wire logic prst_n,
    input wire logic fl_busy_r,
    input wire logic ee_busy_r
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [15:0] fl_len_r;
    logic [15:0] ee_len_r;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    // busy run lengths, cleared whenever the flag drops
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            fl_len_r <= 16'h0000;
        else
            fl_len_r <= fl_busy_r ? fl_len_r + 16'h0001 : 16'h0000;
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            ee_len_r <= 16'h0000;
        else
            ee_len_r <= ee_busy_r ? ee_len_r + 16'h0001 : 16'h0000;
    end

    chk_sck_high_len: assert property ($rose(sck) |-> sck[*4] ##1 !sck)
        else $error("serial clock high phase is not four cycles");
    chk_sck_low_len: assert property ($fell(sck) |-> !sck[*4])
        else $error("serial clock low phase shorter than four cycles");
    chk_mosi_stable: assert property (sck |-> $stable(mosi))
        else $error("programmer data moved while serial clock high");
    chk_miso_stable: assert property (sck |-> $stable(miso))
        else $error("device data moved while serial clock high");
    chk_idle_session: assert property (prst_n |-> !sck)
        else $error("serial clock ran outside the programming session");
    chk_fl_busy_len: assert property ($fell(fl_busy_r) |-> fl_len_r == FL_CYC)
        else $error("flash busy length differs from the programming time");
    chk_ee_busy_len: assert property ($fell(ee_busy_r) |-> ee_len_r == EE_CYC)
        else $error("eeprom busy length differs from the programming time");
    // the closing high phase of the command frame may overlap the first busy cycles
    chk_fl_busy_quiet: assert property (fl_busy_r |-> !$rose(sck))
        else $error("serial traffic during a flash page write");
    chk_ee_busy_quiet: assert property (ee_busy_r |-> !$rose(sck))
        else $error("serial traffic during an eeprom byte write");
endmodule

// ### bench/serial_prog_write_poll_tb.sv
// self-checking bench: programmer end and device end joined over the link
`define CHK(got, exp) \
    begin \
        comparisons++; \
        if ((got) !== (exp)) \
        begin \
            mismatches++; \
            $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); \
        end \
    end

module serial_prog_write_poll_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import spw_pkg::*;

    // shortened timings so a run stays small
    localparam int FL_SIM = 100;
    localparam int EE_SIM = 80;

    logic             clk;
    logic             nrst;
    logic             sess_en;
    logic             cmd_valid;
    logic [CMD_W-1:0] cmd_data;
    logic             cmd_ready_r;
    logic             rsp_valid_r;
    logic [7:0]       rsp_data_r;
    logic             prog_mode_r;
    logic             fl_busy_r;
    logic             ee_busy_r;
    logic             cmd_drop_r;
    logic             rdy_s;
    int               mismatches;
    int               comparisons;
    logic [8:0]       exp_q[$];
    logic [7:0]       fl_lo[256];
    logic [7:0]       fl_hi[256];
    logic [7:0]       bf_lo[64];
    logic [7:0]       bf_hi[64];
    logic [7:0]       ee[16];

    spw_if lnk();

    spw_prog #(.WD_FL(200), .WD_EE(150), .DEPTH(FIFO_DEPTH)) i_spw_prog
    (
        .clk(clk), .nrst(nrst), .sess_en(sess_en), .cmd_valid(cmd_valid),
        .cmd_ready_r(cmd_ready_r), .cmd_data(cmd_data), .rsp_valid_r(rsp_valid_r),
        .rsp_data_r(rsp_data_r), .lnk(lnk.prog)
    );
    spw_dev #(.PSEL_W(2), .EE_AW(4), .FL_CYC(FL_SIM), .EE_CYC(EE_SIM)) i_spw_dev
    (
        .clk(clk), .nrst(nrst), .lnk(lnk.dev), .prog_mode_r(prog_mode_r),
        .fl_busy_r(fl_busy_r), .ee_busy_r(ee_busy_r), .cmd_drop_r(cmd_drop_r)
    );
    spw_link_monitor #(.FL_CYC(FL_SIM), .EE_CYC(EE_SIM)) i_spw_link_monitor
    (
        .clk(clk), .nrst(nrst), .sck(lnk.sck), .mosi(lnk.mosi), .miso(lnk.miso),
        .prst_n(lnk.prst_n), .fl_busy_r(fl_busy_r), .ee_busy_r(ee_busy_r)
    );

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // ready is sampled mid-cycle so the handshake never races the design edge
    always @(negedge clk)
        rdy_s = cmd_ready_r;

    // every frame answers once; only reads carry a checked byte
    always @(negedge clk)
    begin
        if (rsp_valid_r === 1'b1 && exp_q.size() != 0)
        begin
            if (exp_q[0][8])
                `CHK(rsp_data_r, exp_q[0][7:0])
            void'(exp_q.pop_front());
        end
    end

    task automatic conclude();
        $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // arrays and page buffer come out of reset erased
    task automatic model_reset();
        for (int i = 0; i < 256; i++)
        begin
            fl_lo[i] = ERASED;
            fl_hi[i] = ERASED;
            if (i < 64)
                bf_lo[i] = ERASED;
            if (i < 64)
                bf_hi[i] = ERASED;
            if (i < 16)
                ee[i] = ERASED;
        end
    endtask

    // hold valid and data until the edge where ready is seen high
    task automatic push(logic [7:0] op, logic [15:0] a, logic [7:0] d, logic [8:0] e);
        int n;
        n = 0;
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_data <= {op, a, d};
        do
        begin
            @(posedge clk);
            n++;
        end
        while (rdy_s !== 1'b1 && n < 50000);
        cmd_valid <= 1'b0;
        exp_q.push_back(e);
    endtask

    task automatic ld(logic hi, logic [13:0] w, logic [7:0] d);
        push(hi ? OP_LOAD_HI : OP_LOAD_LO, {2'b00, w}, d, 9'h000);
        if (hi)
            bf_hi[w[5:0]] = d;
        else
            bf_lo[w[5:0]] = d;
    endtask

    task automatic wr_page(int p);
        push(OP_WR_PAGE, 16'(p * 64), 8'h00, 9'h000);
        for (int j = 0; j < 64; j++)
        begin
            fl_lo[p * 64 + j] = bf_lo[j];
            fl_hi[p * 64 + j] = bf_hi[j];
            bf_lo[j] = ERASED;
            bf_hi[j] = ERASED;
        end
    endtask

    task automatic rd_fl(int w);
        push(OP_RD_LO, 16'(w), 8'h00, {1'b1, fl_lo[w]});
        push(OP_RD_HI, 16'(w), 8'h00, {1'b1, fl_hi[w]});
    endtask

    task automatic ee_wr(int a, logic [7:0] d);
        push(OP_EE_WR, 16'(a), d, 9'h000);
        ee[a] = d;
    endtask

    task automatic ee_rd(int a);
        push(OP_EE_RD, 16'(a), 8'h00, {1'b1, ee[a]});
    endtask

    task automatic drain(string name);
        int n;
        n = 0;
        while (exp_q.size() != 0 && n < 40000)
        begin
            @(posedge clk);
            n++;
        end
        `CHK(1'(exp_q.size() == 0), 1'b1)
        $display("test %s done", name);
    endtask

    initial
    begin
        repeat (60000) @(posedge clk);
        mismatches++;
        $display("watchdog expired");
        conclude();
    end

    initial
    begin
        nrst = 1'b0;
        sess_en = 1'b0;
        cmd_valid = 1'b0;
        cmd_data = '0;
        mismatches = 0;
        comparisons = 0;
        model_reset();
        void'($urandom(32'h22993217));
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        sess_en <= 1'b1;
        // page 1: edge words loaded low byte first, then committed
        for (int i = 0; i < 8; i++)
        begin
            ld(1'b0, 14'(i < 4 ? 64 + i : 120 + i), 8'($urandom));
            ld(1'b1, 14'(i < 4 ? 64 + i : 120 + i), 8'($urandom));
        end
        wr_page(1);
        for (int i = 0; i < 8; i++)
            rd_fl(i < 4 ? 64 + i : 120 + i);
        rd_fl(74);
        rd_fl(0);
        drain("flash_page");
        `CHK(prog_mode_r, 1'b1)
        // page 2 with a lone low byte: buffer must be erased after the last commit
        ld(1'b0, 14'd131, 8'($urandom));
        wr_page(2);
        rd_fl(131);
        rd_fl(64);
        drain("flash_partial");
        // eeprom overwrite without erase, last write of the erased value
        ee_wr(0, 8'($urandom));
        ee_wr(15, 8'($urandom));
        ee_wr(0, 8'($urandom));
        ee_wr(15, ERASED);
        ee_rd(0);
        ee_rd(15);
        ee_rd(7);
        drain("eeprom");
        // session closed: fifo fills to its depth and refuses
        @(posedge clk);
        sess_en <= 1'b0;
        repeat (4) @(posedge clk);
        `CHK(prog_mode_r, 1'b0)
        `CHK(lnk.prst_n, 1'b1)
        for (int a = 0; a < 8; a++)
            ee_rd(a);
        @(negedge clk);
        `CHK(cmd_ready_r, 1'b0)
        @(posedge clk);
        sess_en <= 1'b1;
        ee_rd(15);
        drain("fifo_full");
        `CHK(cmd_drop_r, 1'b0)
        // reset mid-run erases the arrays again
        @(posedge clk);
        nrst <= 1'b0;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        model_reset();
        ee_rd(0);
        rd_fl(64);
        drain("second_reset");
        conclude();
    end
endmodule
